//--- include/asr_pkg.sv
package asr_pkg;
	localparam int ADDR_W = 11;
	localparam int DATA_W = 8;
	localparam int CLK_PERIOD_NS = 8;
	// Minimum and maximum times both round up to whole cycles.
	localparam int T_RC_NS = 45;
	localparam int T_AA_NS = 45;
	localparam int T_WC_NS = 45;
	localparam int T_WP_NS = 20;
	localparam int T_AW_NS = 40;
	localparam int T_DW_NS = 20;
	localparam int T_DH_NS = 5;
	localparam int T_EW_NS = 45;
	localparam int T_HZ_NS = 20;
	localparam int RD_WAIT_CYC = (T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 2;
	localparam int RC_CYC = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int AW_CYC = (T_AW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DW_CYC = (T_DW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DH_CYC = (T_DH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int EW_CYC = (T_EW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WC_CYC = (T_WC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HZ_CYC = (T_HZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
	localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RD = 3'b001,
		ST_RD_END = 3'b010,
		ST_WR_SET = 3'b011,
		ST_WR_PULSE = 3'b100,
		ST_WR_HOLD = 3'b101,
		ST_TURN = 3'b110
	} asr_state_t;
endpackage

//--- rtl/asr_host.sv
`timescale 1ns/1ns
// What the memory and its host must do
// RULE_01: Device drives addressed word within address access time of stable address.
// RULE_02: Host holds each read address for at least read cycle time.
// RULE_03: Device keeps old read data briefly after an address change.
// RULE_04: Data is valid within chip-select access time after select falls.
// RULE_05: Bus leaves high impedance no sooner than a minimum after select falls.
// RULE_06: Device releases bus within a bounded delay after select rises.
// RULE_07: Device powers down after select rises, powers up at once.
// RULE_08: Output enable low with strobe high drives data within enable access.
// RULE_09: Output enable high releases bus within a bounded delay.
// RULE_10: Write strobe low with select low stops device driving the bus.
// RULE_11: Host keeps write strobe low at least the minimum pulse width.
// RULE_12: Host sets write data up before the strobe rises; stored there.
// RULE_13: Host holds address and select for a minimum before strobe rises.
// RULE_14: Host spaces successive write addresses by the write cycle time.
// RULE_15: Host keeps write strobe high whenever the address changes.
// RULE_16: Write ends at the earlier rising of select or strobe.
// RULE_17: Select falling with strobe keeps the bus in high impedance.
// RULE_18: Device may drive again shortly after strobe rises with enables low.
// RULE_19: Host never drives data while the device may drive the bus.
// RULE_20: Select-ended write needs data setup before and hold after select rises.
// RULE_21: Select-ended write holds select low the minimum enable time.
// RULE_22: Memory is 2048 words of 8 bits on a shared data bus.
// RULE_23: Never-written locations read as undefined.
module asr_host #(
	parameter int ADDR_W = asr_pkg::ADDR_W,
	parameter int DATA_W = asr_pkg::DATA_W
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CE,
	input wire logic REQ_VALID,
	output logic REQ_READY,
	input wire logic REQ_WRITE,
	input wire logic [ADDR_W-1:0] REQ_ADDR,
	input wire logic [DATA_W-1:0] REQ_WDATA,
	output logic RSP_VALID,
	output logic [DATA_W-1:0] RSP_RDATA,
	output logic [ADDR_W-1:0] WORD_ADDRESS,
	output logic CHIP_SEL_N,
	output logic OUT_EN_N,
	output logic WRITE_N,
	input wire logic [DATA_W-1:0] SHARED_DATA_BUS_I,
	output logic [DATA_W-1:0] SHARED_DATA_BUS_O,
	output logic SHARED_DATA_BUS_OE_N
);
	asr_pkg::asr_state_t state_q, state_d;
	logic [asr_pkg::CNT_W-1:0] cnt_q, cnt_d;
	logic [DATA_W-1:0] sync1_q, sync2_q;
	logic take;
	logic cnt_done;

	// The bus input is asynchronous to CLK, so it is synchronised before capture.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else if (CE) begin
			sync1_q <= SHARED_DATA_BUS_I;
			sync2_q <= sync1_q;
		end
	end

	assign REQ_READY = (state_q == asr_pkg::ST_IDLE);
	assign take = REQ_VALID && REQ_READY;
	assign cnt_done = (cnt_q == asr_pkg::CNT_ZERO);

	// A wait of one cycle or less loads zero, so a zero-length gap cannot wrap the counter.
	function automatic logic [asr_pkg::CNT_W-1:0] cyc(input int n);
		cyc = (n > 1) ? asr_pkg::CNT_W'(n - 1) : asr_pkg::CNT_ZERO;
	endfunction

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_done ? cnt_q : cnt_q - asr_pkg::CNT_ONE;
		unique case (state_q)
			asr_pkg::ST_IDLE: begin
				if (take && REQ_WRITE) begin
					state_d = asr_pkg::ST_WR_SET;
					cnt_d = asr_pkg::CNT_ZERO;
				end else if (take) begin
					state_d = asr_pkg::ST_RD;
					// RULE_01 RULE_02 RULE_04 RULE_08
					cnt_d = cyc(asr_pkg::RD_WAIT_CYC);
				end
			end
			asr_pkg::ST_RD: begin
				if (cnt_done) begin
					state_d = asr_pkg::ST_RD_END;
				end
			end
			asr_pkg::ST_RD_END: begin
				// RULE_06 RULE_09 RULE_19
				state_d = asr_pkg::ST_TURN;
				cnt_d = cyc(asr_pkg::HZ_CYC);
			end
			asr_pkg::ST_WR_SET: begin
				// RULE_15
				state_d = asr_pkg::ST_WR_PULSE;
				cnt_d = cyc(asr_pkg::EW_CYC);
			end
			asr_pkg::ST_WR_PULSE: begin
				// RULE_11 RULE_12 RULE_13 RULE_16 RULE_21
				if (cnt_done) begin
					state_d = asr_pkg::ST_WR_HOLD;
					cnt_d = cyc(asr_pkg::DH_CYC);
				end
			end
			asr_pkg::ST_WR_HOLD: begin
				// RULE_20
				if (cnt_done) begin
					state_d = asr_pkg::ST_TURN;
					cnt_d = cyc(asr_pkg::WC_CYC - asr_pkg::EW_CYC);
				end
			end
			asr_pkg::ST_TURN: begin
				// RULE_14
				if (cnt_done) begin
					state_d = asr_pkg::ST_IDLE;
				end
			end
			default: begin
				state_d = asr_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_q <= asr_pkg::ST_IDLE;
			cnt_q <= asr_pkg::CNT_ZERO;
		end else if (CE) begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	// Pins come from flip-flops so no glitch reaches the memory.
	// Select and strobe rise together; the write thus ends on the same edge.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			WORD_ADDRESS <= '0;
			CHIP_SEL_N <= 1'b1;
			OUT_EN_N <= 1'b1;
			WRITE_N <= 1'b1;
			SHARED_DATA_BUS_O <= '0;
			SHARED_DATA_BUS_OE_N <= 1'b1;
			RSP_VALID <= 1'b0;
			RSP_RDATA <= '0;
		end else if (CE) begin
			RSP_VALID <= 1'b0;
			if (take) begin
				// RULE_15
				WORD_ADDRESS <= REQ_ADDR;
				SHARED_DATA_BUS_O <= REQ_WDATA;
			end
			unique case (state_d)
				asr_pkg::ST_RD: begin
					CHIP_SEL_N <= 1'b0;
					OUT_EN_N <= 1'b0;
				end
				asr_pkg::ST_WR_SET: begin
					// RULE_17 RULE_19
					CHIP_SEL_N <= 1'b0;
					OUT_EN_N <= 1'b1;
				end
				asr_pkg::ST_WR_PULSE: begin
					WRITE_N <= 1'b0;
					SHARED_DATA_BUS_OE_N <= 1'b0;
				end
				asr_pkg::ST_WR_HOLD: begin
					// RULE_16 RULE_20
					CHIP_SEL_N <= 1'b1;
					WRITE_N <= 1'b1;
				end
				default: begin
					CHIP_SEL_N <= 1'b1;
					OUT_EN_N <= 1'b1;
					WRITE_N <= 1'b1;
					SHARED_DATA_BUS_OE_N <= 1'b1;
				end
			endcase
			if (state_q == asr_pkg::ST_RD_END) begin
				// RULE_22 RULE_23
				RSP_VALID <= 1'b1;
				RSP_RDATA <= sync2_q;
			end
		end
	end

	// Write strobe only falls one cycle after the address was set.
	a_addr_strobe_high: assert property (@(posedge CLK) disable iff (!RST_N)
		$changed(WORD_ADDRESS) |-> $past(WRITE_N)) // RULE_15
		else $error("address changed while write strobe low");

	sequence s_strobe_fall;
		$fell(WRITE_N);
	endsequence

	a_write_pulse_width: assert property (@(posedge CLK) disable iff (!RST_N || !CE)
		s_strobe_fall |-> !WRITE_N [*3]) // RULE_11
		else $error("write pulse too short");

	a_select_before_end: assert property (@(posedge CLK) disable iff (!RST_N || !CE)
		s_strobe_fall |-> !CHIP_SEL_N [*6]) // RULE_13
		else $error("select not held before write end");

	a_data_during_strobe: assert property (@(posedge CLK) disable iff (!RST_N)
		!WRITE_N |-> !SHARED_DATA_BUS_OE_N && OUT_EN_N) // RULE_12
		else $error("write data not driven during strobe");

	a_no_contention: assert property (@(posedge CLK) disable iff (!RST_N)
		!OUT_EN_N |-> SHARED_DATA_BUS_OE_N) // RULE_19
		else $error("host drives bus while device may drive");

	a_strobe_not_with_sel: assert property (@(posedge CLK) disable iff (!RST_N)
		$fell(CHIP_SEL_N) |-> WRITE_N) // RULE_17
		else $error("select and strobe fell together");

	a_data_hold: assert property (@(posedge CLK) disable iff (!RST_N || !CE)
		$rose(WRITE_N) |-> !SHARED_DATA_BUS_OE_N && $stable(SHARED_DATA_BUS_O)) // RULE_20
		else $error("write data not held after end of write");

	a_read_length: assert property (@(posedge CLK) disable iff (!RST_N || !CE)
		$fell(OUT_EN_N) |-> !OUT_EN_N [*8]) // RULE_02
		else $error("read cycle too short");

	a_end_together: assert property (@(posedge CLK) disable iff (!RST_N)
		$rose(WRITE_N) |-> $rose(CHIP_SEL_N)) // RULE_16
		else $error("write end edges not aligned");

	a_read_answer: assert property (@(posedge CLK) disable iff (!RST_N || !CE)
		$rose(OUT_EN_N) |-> ##1 RSP_VALID) // RULE_01
		else $error("read answer not given at release");
endmodule

//--- verification/asr_sram_model.sv
`timescale 1ns/1ns
module asr_sram_model (
	input wire logic [10:0] word_address,
	input wire logic chip_sel_n,
	input wire logic out_en_n,
	input wire logic write_n,
	input wire logic [7:0] host_data,
	input wire logic host_oe_n,
	output logic [7:0] bus_level,
	output logic clash
);
	logic [7:0] mem [0:2047];
	logic [7:0] last;
	wire rd_on = !chip_sel_n && !out_en_n && write_n;
	// Read data is withheld for the whole access time, so an early sample gets junk.
	wire #(45, 0) rd_ok = rd_on;
	wire wr_on = !chip_sel_n && !write_n;
	always @(negedge wr_on) begin
		mem[word_address] <= bus_level;
	end
	always @* begin
		if (!host_oe_n)
			last = host_data;
		else if (rd_ok)
			last = mem[word_address];
	end
	// A released bus shows the inverse of its last value, so a stale sample never passes.
	assign bus_level = !host_oe_n ? host_data : rd_ok ? mem[word_address] : ~last;
	assign clash = !host_oe_n && rd_ok;
endmodule

//--- verification/async_sram_2k_by_8_port_test.sv
`timescale 1ns/1ns
module async_sram_2k_by_8_port_test;
	logic clk, rst_n, ce, req_valid, req_ready, req_write, rsp_valid;
	logic [10:0] req_addr, word_address;
	logic [7:0] req_wdata, rsp_rdata, bus_level, bus_o;
	logic chip_sel_n, out_en_n, write_n, bus_oe_n, clash;
	int bad_count = 0;
	int tests_run = 0;
	asr_host DUT (.CLK(clk), .RST_N(rst_n), .CE(ce), .REQ_VALID(req_valid),
		.REQ_READY(req_ready), .REQ_WRITE(req_write), .REQ_ADDR(req_addr),
		.REQ_WDATA(req_wdata), .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata),
		.WORD_ADDRESS(word_address), .CHIP_SEL_N(chip_sel_n), .OUT_EN_N(out_en_n),
		.WRITE_N(write_n), .SHARED_DATA_BUS_I(bus_level), .SHARED_DATA_BUS_O(bus_o),
		.SHARED_DATA_BUS_OE_N(bus_oe_n));
	asr_sram_model mem_model (.word_address(word_address), .chip_sel_n(chip_sel_n),
		.out_en_n(out_en_n), .write_n(write_n), .host_data(bus_o), .host_oe_n(bus_oe_n),
		.bus_level(bus_level), .clash(clash));
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	task automatic stop_test();
		$display("compares %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: byte %h expected %h", $time, got, exp);
		end
	endtask
	task automatic check_bit(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: flag %b expected %b", $time, got, exp);
		end
	endtask
	task automatic timed_out();
		bad_count++;
		$display("mismatch at %0t: wait timed out", $time);
		stop_test();
	endtask
	always @(posedge clk) begin
		if (clash === 1'b1)
			check_bit(clash, 1'b0);
	end
	// Waits for the handshake, then lets the taking edge pass before dropping valid.
	task automatic send(input logic wr, input logic [10:0] a, input logic [7:0] d);
		int n;
		n = 0;
		// One edge passes first, so valid never falls and rises in one time step.
		@(posedge clk);
		#1;
		req_valid = 1;
		req_write = wr;
		req_addr = a;
		req_wdata = d;
		while (req_ready !== 1'b1 && n < 40) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 40)
			timed_out();
		@(posedge clk);
		#1;
		req_valid = 0;
	endtask
	task automatic read_back(input logic [10:0] a, input logic [7:0] exp, input int lat);
		int k;
		send(0, a, 8'h00);
		k = 1;
		while (rsp_valid !== 1'b1 && k < 40) begin
			@(posedge clk);
			#1;
			k++;
		end
		if (k >= 40)
			timed_out();
		check_byte(rsp_rdata, exp);
		if (lat > 0)
			check_bit(k == lat, 1'b1);
	endtask
	task automatic t_idle();
		check_bit(chip_sel_n, 1'b1);
		check_bit(write_n, 1'b1);
		check_bit(out_en_n, 1'b1);
		check_bit(bus_oe_n, 1'b1);
		$display("test idle done");
	endtask
	task automatic t_write_read();
		send(1, 11'h000, 8'hA5);
		send(1, 11'h7FF, 8'h5A);
		send(1, 11'h001, 8'hFF);
		read_back(11'h000, 8'hA5, 10);
		read_back(11'h7FF, 8'h5A, 10);
		read_back(11'h001, 8'hFF, 10);
		send(1, 11'h001, 8'h00);
		read_back(11'h001, 8'h00, 10);
		$display("test write read done");
	endtask
	task automatic t_unwritten();
		read_back(11'h123, 8'hXX, 10);
		$display("test unwritten done");
	endtask
	task automatic t_ce_freeze();
		int k;
		send(1, 11'h2C4, 8'h3C);
		send(0, 11'h2C4, 8'h00);
		ce = 0;
		repeat (6) @(posedge clk);
		#1;
		check_bit(rsp_valid, 1'b0);
		check_bit(chip_sel_n, 1'b0);
		ce = 1;
		// The frozen read must finish with the stored byte once the clock enable returns.
		k = 0;
		while (rsp_valid !== 1'b1 && k < 40) begin
			@(posedge clk);
			#1;
			k++;
		end
		if (k >= 40)
			timed_out();
		check_byte(rsp_rdata, 8'h3C);
		read_back(11'h2C4, 8'h3C, 0);
		$display("test clock enable done");
	endtask
	initial begin
		rst_n = 0;
		ce = 1;
		req_valid = 0;
		req_write = 0;
		req_addr = 11'h000;
		req_wdata = 8'h00;
		repeat (5) @(posedge clk);
		#1;
		rst_n = 1;
		t_idle();
		t_write_read();
		t_unwritten();
		t_ce_freeze();
		stop_test();
	end
endmodule
